// File: adder_funnel_pkg.sv
// shared constants, types and layouts for the adder and funnel slice
package adder_funnel_pkg;
   localparam int          WORD_W      = 32;
   localparam int          GROUP_W     = 4;
   localparam int          GROUP_N     = 8;
   localparam int          ADDR_W      = 8;
   // apb register byte offsets
   localparam logic [7:0]  OFF_CTRL    = 8'h00;
   localparam logic [7:0]  OFF_STATUS  = 8'h04;
   localparam logic [7:0]  OFF_MIRROR  = 8'h08;
   localparam logic [7:0]  OFF_ACC     = 8'h0C;
   localparam logic [7:0]  OFF_OPERAND = 8'h10;
   localparam logic [7:0]  OFF_CARRY   = 8'h14;
   // control register fields
   localparam int          CTRL_ACCEL_BIT = 0;
   localparam int          CTRL_PREC_LSB  = 1;
   localparam logic [2:0]  CTRL_RESET     = 3'h0;
   // status register fields
   localparam int          STAT_ADDER_BIT = 0;
   localparam int          STAT_HIGH_BIT  = 1;
   // word constants, bit 0 is the most significant position
   localparam logic [31:0] WORD_ZERO      = 32'h00000000;
   localparam logic [31:0] WORD_ONES      = 32'hFFFFFFFF;
   localparam logic [31:0] KEEP_LOW_BYTES = 32'h00FFFFFF;
   localparam logic [31:0] MASK_LOW_HALF  = 32'h0000FFFF;
   localparam logic [31:0] MASK_HIGH_HALF = 32'hFFFF0000;
   localparam logic [31:0] MASK_DISP      = 32'h00000FFF;
   localparam logic [31:0] MASK_IMM_EVEN  = 32'h0000FF00;
   localparam logic [31:0] MASK_IMM_ODD   = 32'h000000FF;
   localparam logic [31:0] MASK_PREC_8    = 32'hFF000000;
   localparam logic [31:0] MASK_PREC_10   = 32'hFFFF0000;
   localparam logic [31:0] MASK_PREC_12   = 32'hFFFFFF00;
   typedef logic [0:31] word_t;
   typedef enum logic [2:0] {
      SD_NONE = 3'b000, SD_FULL = 3'b001, SD_LOW_HALF = 3'b010, SD_HIGH_HALF = 3'b011,
      SD_DISP = 3'b100, SD_IMM_BYTE = 3'b101, SD_FP_LONG = 3'b110
   } sd_sel_t;
   typedef enum logic [1:0] {
      PREC_8 = 2'b00, PREC_10 = 2'b01, PREC_12 = 2'b10, PREC_14 = 2'b11
   } prec_t;
   typedef struct packed {
      logic [7:0]  paddr;
      logic        psel;
      logic        penable;
      logic        pwrite;
      logic [31:0] pwdata;
   } apb_req_t;
   typedef struct packed {
      logic [31:0] prdata;
      logic        pready;
      logic        pslverr;
   } apb_rsp_t;
   typedef struct packed {
      logic    mirror_reset;
      logic    mirror_reset_byte0;
      logic    mirror_set;
      logic    mirror_decond;
      logic    mirror_copy_acc;
      logic    acc_reset;
      logic    acc_set;
      logic    funnel_strobe;
      logic    operand_load;
      logic    subtract;
      logic    gate_carry;
      logic    gate_operand;
      logic    gate_cross;
      sd_sel_t sd_sel;
      logic    odd_addr;
      logic    latch_clear;
      logic    latch_strobe;
   } ctl_t;
endpackage

// File: carry_lookahead_adder_funnel.sv
// adder slice: carry mirror, carry network, funnel, accumulator, apb access
module carry_lookahead_adder_funnel
   import adder_funnel_pkg::*;
(
   input  logic     ref_clk,
   input  logic     rst_n,
   input  apb_req_t apb_req,
   output apb_rsp_t apb_rsp,
   input  ctl_t     ctl,
   input  word_t    storage_data,
   input  word_t    hw_data,
   output word_t    acc_out,
   output word_t    operand_out,
   output logic     adder_carry_out_latch,
   output logic     high_bit_carry_latch
);
   word_t       mirror;
   word_t       acc;
   word_t       operand;
   word_t       carry_vec;
   word_t       carry_word;
   word_t       funnel;
   logic        carry_top;
   logic [2:0]  ctrl;
   logic [31:0] prdata;
   logic        apb_setup;
   logic        apb_write;
   logic        addr_hit;
   prec_t       prec;
   logic        accel_en;

   assign accel_en = ctrl[CTRL_ACCEL_BIT];
   assign prec     = prec_t'(ctrl[CTRL_PREC_LSB +: 2]);

   // carry network sees operand and mirror with no gating
   carry_lookahead_network u_network (
      .operand   (operand),
      .mirror    (mirror),
      .carry_in  (ctl.subtract),
      .carry_vec (carry_vec),
      .carry_top (carry_top)
   );

   // output n comes from position n+1; no output numbered 31
   assign carry_word = {carry_vec[1:31], 1'b0};

   // funnel merges every enabled source
   register_input_funnel u_funnel (
      .sd_sel       (ctl.sd_sel),
      .prec         (prec),
      .odd_addr     (ctl.odd_addr),
      .storage_data (storage_data),
      .hw_data      (hw_data),
      .carry_word   (carry_word),
      .operand      (operand),
      .gate_carry   (ctl.gate_carry),
      .gate_operand (ctl.gate_operand),
      .cross_en     (ctl.gate_cross & accel_en),
      .funnel       (funnel)
   );

   // carry mirror: reset, set, copy, byte zero clear, then xor entry
   always_ff @(posedge ref_clk or negedge rst_n) begin
      if (!rst_n) begin
         mirror <= WORD_ZERO;
      end else if (ctl.mirror_reset) begin
         mirror <= WORD_ZERO;
      end else if (ctl.mirror_set) begin
         mirror <= WORD_ONES;
      end else if (ctl.mirror_copy_acc) begin
         mirror <= acc;
      end else if (ctl.mirror_reset_byte0) begin
         mirror <= mirror & KEEP_LOW_BYTES;
      end else if (ctl.funnel_strobe && !ctl.mirror_decond) begin
         // decondition keeps carries from feeding back
         mirror <= mirror ^ funnel;
      end
   end

   // accumulator: reset, set, or xor funnel entry
   always_ff @(posedge ref_clk or negedge rst_n) begin
      if (!rst_n) begin
         acc <= WORD_ZERO;
      end else if (ctl.acc_reset) begin
         acc <= WORD_ZERO;
      end else if (ctl.acc_set) begin
         acc <= WORD_ONES;
      end else if (ctl.funnel_strobe) begin
         acc <= acc ^ funnel;
      end
   end

   // operand register loads the funnel
   always_ff @(posedge ref_clk or negedge rst_n) begin
      if (!rst_n) begin
         operand <= WORD_ZERO;
      end else if (ctl.operand_load) begin
         operand <= funnel;
      end
   end

   // condition carry latches, set wins over clear
   always_ff @(posedge ref_clk or negedge rst_n) begin
      if (!rst_n) begin
         adder_carry_out_latch <= 1'b0;
         high_bit_carry_latch  <= 1'b0;
      end else begin
         if (ctl.latch_strobe && carry_top) begin
            adder_carry_out_latch <= 1'b1;
         end else if (ctl.latch_clear) begin
            adder_carry_out_latch <= 1'b0;
         end
         if (ctl.latch_strobe && carry_word[0]) begin
            high_bit_carry_latch <= 1'b1;
         end else if (ctl.latch_clear) begin
            high_bit_carry_latch <= 1'b0;
         end
      end
   end

   assign acc_out     = acc;
   assign operand_out = operand;

   // apb decode
   assign apb_setup = apb_req.psel && !apb_req.penable;
   assign apb_write = apb_req.psel && apb_req.penable && apb_req.pwrite;
   always_comb begin
      case (apb_req.paddr)
         OFF_CTRL, OFF_STATUS, OFF_MIRROR, OFF_ACC, OFF_OPERAND, OFF_CARRY: addr_hit = 1'b1;
         default: addr_hit = 1'b0;
      endcase
   end

   // control register, written in the access phase
   always_ff @(posedge ref_clk or negedge rst_n) begin
      if (!rst_n) begin
         ctrl <= CTRL_RESET;
      end else if (apb_write && apb_req.paddr == OFF_CTRL) begin
         ctrl <= apb_req.pwdata[2:0];
      end
   end

   // read data captured in the setup cycle
   always_ff @(posedge ref_clk or negedge rst_n) begin
      if (!rst_n) begin
         prdata <= WORD_ZERO;
      end else if (apb_setup) begin
         case (apb_req.paddr)
            OFF_CTRL:    prdata <= {29'h00000000, ctrl};
            OFF_STATUS:  prdata <= {30'h00000000, high_bit_carry_latch, adder_carry_out_latch};
            OFF_MIRROR:  prdata <= mirror;
            OFF_ACC:     prdata <= acc;
            OFF_OPERAND: prdata <= operand;
            OFF_CARRY:   prdata <= carry_word;
            default:     prdata <= WORD_ZERO;
         endcase
      end
   end

   // zero wait states, error on unmapped access
   assign apb_rsp.prdata  = prdata;
   assign apb_rsp.pready  = 1'b1;
   assign apb_rsp.pslverr = apb_req.psel && apb_req.penable && !addr_hit;

   // checks on the slice behaviour
   default clocking cb @(posedge ref_clk); endclocking
   default disable iff (!rst_n);

   sequence s_ctrl_setup;
      apb_req.psel && !apb_req.penable && apb_req.pwrite && apb_req.paddr == OFF_CTRL;
   endsequence
   sequence s_access;
      apb_req.psel && apb_req.penable;
   endsequence
   sequence s_copy;
      ctl.mirror_copy_acc && !ctl.mirror_reset && !ctl.mirror_set;
   endsequence
   sequence s_plain_step;
      !ctl.mirror_reset && !ctl.mirror_set && !ctl.mirror_copy_acc
      && !ctl.mirror_reset_byte0 && !ctl.acc_reset && !ctl.acc_set;
   endsequence
   sequence s_storage_only;
      !ctl.gate_carry && !ctl.gate_operand && !ctl.gate_cross;
   endsequence

   a_mirror_clear_all: assert property (
      ctl.mirror_reset |=> mirror == WORD_ZERO)
      else $error("mirror not cleared");
   a_mirror_clear_byte: assert property (
      ctl.mirror_reset_byte0 && !ctl.mirror_reset && !ctl.mirror_set && !ctl.mirror_copy_acc
      |=> mirror == ($past(mirror) & KEEP_LOW_BYTES))
      else $error("byte zero clear wrong");
   a_mirror_set_ones: assert property (
      ctl.mirror_set && !ctl.mirror_reset |=> mirror == WORD_ONES)
      else $error("mirror not set to ones");
   a_mirror_decond: assert property (
      s_plain_step and ctl.mirror_decond |=> $stable(mirror))
      else $error("deconditioned mirror changed");
   a_mirror_realign: assert property (
      s_copy ##1 (s_plain_step and (!ctl.funnel_strobe || ctl.mirror_decond))
      |=> mirror == $past(acc, 2))
      else $error("mirror not realigned to accumulator");
   a_mirror_xor: assert property (
      s_plain_step and ctl.funnel_strobe && !ctl.mirror_decond
      |=> mirror == ($past(mirror) ^ $past(funnel)))
      else $error("mirror entry not xor");
   a_carry_gen: assert property (
      operand[5] && !mirror[5] |-> carry_vec[5])
      else $error("carry not generated");
   a_carry_prop: assert property (
      mirror[10] && carry_vec[11] |-> carry_vec[10])
      else $error("carry not propagated");
   a_group_top: assert property (
      !operand[4] && &mirror[4:7] && carry_vec[8] |-> carry_vec[4])
      else $error("group bypass missed carry");
   a_acc_xor: assert property (
      s_plain_step and ctl.funnel_strobe |=> acc == ($past(acc) ^ $past(funnel)))
      else $error("accumulator entry not xor");
   a_high_latch: assert property (
      ctl.latch_strobe && carry_vec[1] |=> high_bit_carry_latch)
      else $error("high bit latch not set");
   a_carry_latch: assert property (
      ctl.latch_strobe && carry_top |=> adder_carry_out_latch)
      else $error("carry-out latch not set");
   a_no_out31: assert property (
      !carry_word[31] && carry_word[30] == carry_vec[31])
      else $error("low carry output wrong");
   a_sub_carry: assert property (
      ctl.subtract && mirror[31] |-> carry_word[30])
      else $error("subtract carry missing");
   a_imm_byte: assert property (
      ctl.sd_sel == SD_IMM_BYTE && !ctl.gate_carry && !ctl.gate_operand && !ctl.gate_cross
      |-> funnel == (storage_data & (ctl.odd_addr ? MASK_IMM_ODD : MASK_IMM_EVEN)))
      else $error("compare immediate byte wrong");
   a_cross_gate: assert property (
      ctl.sd_sel == SD_NONE && !ctl.gate_carry && !ctl.gate_operand && !accel_en
      |-> funnel == WORD_ZERO)
      else $error("crossover without option");
   a_ctrl_write: assert property (
      s_ctrl_setup ##1 s_access |=> ctrl == $past(apb_req.pwdata[2:0]))
      else $error("control write lost");

   // register updates follow their strobes
   a_acc_clear: assert property (
      ctl.acc_reset |=> acc == WORD_ZERO)
      else $error("accumulator not cleared");
   a_acc_set_ones: assert property (
      ctl.acc_set && !ctl.acc_reset |=> acc == WORD_ONES)
      else $error("accumulator not set");
   a_acc_hold: assert property (
      !ctl.acc_reset && !ctl.acc_set && !ctl.funnel_strobe |=> $stable(acc))
      else $error("accumulator moved unstrobed");
   a_operand_load: assert property (
      ctl.operand_load |=> operand == $past(funnel))
      else $error("operand load wrong");
   a_operand_hold: assert property (
      !ctl.operand_load |=> $stable(operand))
      else $error("operand moved unstrobed");
   a_mirror_idle: assert property (
      s_plain_step and !ctl.funnel_strobe |=> $stable(mirror))
      else $error("mirror moved unstrobed");
   a_mirror_copy: assert property (
      s_copy |=> mirror == $past(acc))
      else $error("mirror copy wrong");
   // funnel sources and storage ranges
   a_carry_gate: assert property (
      ctl.gate_carry && !ctl.gate_operand && !ctl.gate_cross && ctl.sd_sel == SD_NONE
      |-> funnel == carry_word)
      else $error("carry gate wrong");
   a_funnel_or: assert property (
      ctl.gate_operand && !ctl.gate_carry && !ctl.gate_cross && ctl.sd_sel == SD_LOW_HALF
      |-> funnel == (operand | (storage_data & MASK_LOW_HALF)))
      else $error("funnel sources not merged");
   a_full_select: assert property (
      s_storage_only and ctl.sd_sel == SD_FULL |-> funnel == storage_data)
      else $error("full word select wrong");
   a_low_half: assert property (
      s_storage_only and ctl.sd_sel == SD_LOW_HALF |-> funnel == (storage_data & MASK_LOW_HALF))
      else $error("halfword select wrong");
   a_high_half: assert property (
      s_storage_only and ctl.sd_sel == SD_HIGH_HALF |-> funnel == (storage_data & MASK_HIGH_HALF))
      else $error("expansion select wrong");
   a_disp_select: assert property (
      s_storage_only and ctl.sd_sel == SD_DISP |-> funnel == (storage_data & MASK_DISP))
      else $error("displacement select wrong");
   a_prec_8: assert property (
      s_storage_only and ctl.sd_sel == SD_FP_LONG && prec == PREC_8
      |-> funnel == (storage_data & MASK_PREC_8))
      else $error("precision 8 select wrong");
   a_prec_10: assert property (
      s_storage_only and ctl.sd_sel == SD_FP_LONG && prec == PREC_10
      |-> funnel == (storage_data & MASK_PREC_10))
      else $error("precision 10 select wrong");
   a_prec_12: assert property (
      s_storage_only and ctl.sd_sel == SD_FP_LONG && prec == PREC_12
      |-> funnel == (storage_data & MASK_PREC_12))
      else $error("precision 12 select wrong");
   a_prec_14: assert property (
      s_storage_only and ctl.sd_sel == SD_FP_LONG && prec == PREC_14
      |-> funnel == storage_data)
      else $error("precision 14 select wrong");
   a_cross_route: assert property (
      ctl.gate_cross && accel_en && ctl.sd_sel == SD_NONE
      && !ctl.gate_carry && !ctl.gate_operand
      |-> funnel[0:15] == hw_data[16:31] && funnel[16:31] == 16'h0000)
      else $error("crossover route wrong");
   // condition latches and carry chain
   a_latch_clear: assert property (
      ctl.latch_clear && !ctl.latch_strobe |=> !adder_carry_out_latch && !high_bit_carry_latch)
      else $error("latches not cleared");
   a_carry_hold: assert property (
      adder_carry_out_latch && !ctl.latch_clear |=> adder_carry_out_latch)
      else $error("carry-out latch dropped");
   a_high_hold: assert property (
      high_bit_carry_latch && !ctl.latch_clear |=> high_bit_carry_latch)
      else $error("high bit latch dropped");
   a_carry_quiet: assert property (
      !ctl.latch_strobe && !ctl.latch_clear |=> $stable(adder_carry_out_latch))
      else $error("carry-out latch moved");
   a_carry_top: assert property (
      carry_top == ((operand[0] && !mirror[0]) || (mirror[0] && carry_vec[1])))
      else $error("top group carry wrong");
   a_group_four: assert property (
      carry_vec[28] == ((operand[28] && !mirror[28]) || (mirror[28] && carry_vec[29])))
      else $error("group carry wrong");
   a_no_sub_carry: assert property (
      !ctl.subtract && !operand[31] |-> !carry_vec[31])
      else $error("carry in without subtract");
   // register bus
   a_ctrl_hold: assert property (
      !(apb_write && apb_req.paddr == OFF_CTRL) |=> $stable(ctrl))
      else $error("control moved without write");
   a_status_read: assert property (
      apb_req.psel && !apb_req.penable && apb_req.paddr == OFF_STATUS
      |=> apb_rsp.prdata[1:0] == $past({high_bit_carry_latch, adder_carry_out_latch}))
      else $error("status read wrong");
endmodule // carry_lookahead_adder_funnel

// File: carry_lookahead_adder_funnel_test.sv
// self-checking testbench for the adder and funnel slice
module carry_lookahead_adder_funnel_test
   import adder_funnel_pkg::*;
;
   timeunit 1ns;
   timeprecision 1ps;

   logic        ref_clk      = 1'b0;
   logic        rst_n        = 1'b0;
   apb_req_t    apb_req      = '0;
   apb_rsp_t    apb_rsp;
   ctl_t        want         = '0;
   ctl_t        ctl;
   word_t       storage_data = '0;
   word_t       hw_data      = '0;
   word_t       acc_out;
   word_t       operand_out;
   logic        carry_out_flag;
   logic        high_carry_flag;
   logic [31:0] rd;
   logic        err;
   int          fails        = 0;
   int          tests_run    = 0;
   int          cycles       = 0;

   // funnel storage selections and the words they should let through
   localparam sd_sel_t sel_tab[10] = '{SD_FULL, SD_LOW_HALF, SD_HIGH_HALF, SD_DISP,
      SD_IMM_BYTE, SD_IMM_BYTE, SD_FP_LONG, SD_FP_LONG, SD_FP_LONG, SD_FP_LONG};
   localparam logic [31:0] exp_tab[10] = '{32'hFFFFFFFF, 32'h0000FFFF, 32'hFFFF0000,
      32'h00000FFF, 32'h0000FF00, 32'h000000FF, 32'hFF000000, 32'hFFFF0000, 32'hFFFFFF00,
      32'hFFFFFFFF};

   carry_lookahead_adder_funnel carry_lookahead_adder_funnel_i (
      .ref_clk               (ref_clk),
      .rst_n                 (rst_n),
      .apb_req               (apb_req),
      .apb_rsp               (apb_rsp),
      .ctl                   (ctl),
      .storage_data          (storage_data),
      .hw_data               (hw_data),
      .acc_out               (acc_out),
      .operand_out           (operand_out),
      .adder_carry_out_latch (carry_out_flag),
      .high_bit_carry_latch  (high_carry_flag)
   );

   sequencer_model sequencer_model_i (
      .want (want),
      .ctl  (ctl)
   );

   // 25 MHz clock
   always #20 ref_clk = ~ref_clk;

   // hang guard
   always @(posedge ref_clk) begin
      cycles <= cycles + 1;
      if (cycles == 5000) begin
         fails++;
         tally_and_finish();
      end
   end

   // verdict and end of run
   task automatic tally_and_finish;
      $display("comparisons %0d mismatches %0d", tests_run, fails);
      if (fails == 0 && tests_run > 0) begin
         $display("NO MISMATCHES");
      end else begin
         $display("MISMATCHES SEEN");
      end
      $finish;
   endtask

   // word compare
   task automatic chk_word(input string what, input logic [31:0] exp, input logic [31:0] got);
      tests_run++;
      if (got !== exp) begin
         fails++;
         $display("wrong value %s expected %h seen %h", what, exp, got);
      end
   endtask

   // single bit compare
   task automatic chk_bit(input string what, input logic exp, input logic got);
      tests_run++;
      if (got !== exp) begin
         fails++;
         $display("wrong value %s expected %b seen %b", what, exp, got);
      end
   endtask

   // one apb transfer, held until pready is seen
   task automatic apb(input logic [7:0] a, input logic w, input logic [31:0] d);
      @(posedge ref_clk);
      apb_req <= '{paddr: a, psel: 1'b1, penable: 1'b0, pwrite: w, pwdata: d};
      @(posedge ref_clk);
      apb_req.penable <= 1'b1;
      do @(posedge ref_clk); while (apb_rsp.pready !== 1'b1);
      rd = apb_rsp.prdata;
      err = apb_rsp.pslverr;
      apb_req.psel <= 1'b0;
      apb_req.penable <= 1'b0;
   endtask

   // one cycle of strobes with funnel data, checked after the edge lands
   task automatic step(input ctl_t c, input word_t sd = '0, input word_t hd = '0);
      @(posedge ref_clk);
      want <= c;
      storage_data <= sd;
      hw_data <= hd;
      @(posedge ref_clk);
      want <= '0;
      @(negedge ref_clk);
   endtask

   // carry out of every position, index 0 is the adder carry-out
   function automatic logic [0:32] carry_ref(input word_t a, input word_t c, input logic sub);
      logic        k;
      logic [0:32] r;
      k = sub;
      r = '0;
      for (int i = 31; i >= 0; i--) begin
         k = (a[i] & ~c[i]) | (c[i] & k);
         r[i] = k;
      end
      return r;
   endfunction

   // reset contents, unmapped access and the read-only accumulator offset
   task automatic reset_values;
      for (int i = 0; i < 6; i++) begin
         apb(8'(4 * i), 1'b0, '0);
         chk_word("reset word", 32'h00000000, rd);
      end
      apb(8'h40, 1'b0, '0);
      chk_bit("unmapped error", 1'b1, err);
      apb(OFF_ACC, 1'b1, 32'h0000FFFF);
      apb(OFF_ACC, 1'b0, '0);
      chk_word("read-only acc", 32'h00000000, rd);
   endtask

   // mirror set, byte clear, xor entry, decondition, full clear
   task automatic mirror_controls;
      step('{mirror_set: 1'b1, acc_reset: 1'b1, sd_sel: SD_NONE, default: 1'b0});
      apb(OFF_MIRROR, 1'b0, '0);
      chk_word("mirror set", 32'hFFFFFFFF, rd);
      step('{mirror_reset_byte0: 1'b1, sd_sel: SD_NONE, default: 1'b0});
      apb(OFF_MIRROR, 1'b0, '0);
      chk_word("mirror byte clear", 32'h00FFFFFF, rd);
      step('{funnel_strobe: 1'b1, sd_sel: SD_FULL, default: 1'b0}, 32'h0F0F0F0F);
      apb(OFF_MIRROR, 1'b0, '0);
      chk_word("mirror xor", 32'h0FF0F0F0, rd);
      step('{funnel_strobe: 1'b1, mirror_decond: 1'b1, sd_sel: SD_FULL, default: 1'b0}, '1);
      apb(OFF_MIRROR, 1'b0, '0);
      chk_word("mirror decond", 32'h0FF0F0F0, rd);
      chk_word("acc xor", 32'hF0F0F0F0, acc_out);
      step('{mirror_reset: 1'b1, sd_sel: SD_NONE, default: 1'b0});
      apb(OFF_MIRROR, 1'b0, '0);
      chk_word("mirror clear", 32'h00000000, rd);
   endtask

   // storage gate selections through the operand load
   task automatic funnel_selects;
      for (int i = 0; i < 10; i++) begin
         apb(OFF_CTRL, 1'b1, (i < 6) ? 32'h00000006 : 32'(2 * (i - 6)));
         step('{operand_load: 1'b1, sd_sel: sel_tab[i], odd_addr: (i == 5), default: 1'b0}, '1);
         chk_word("storage gate", exp_tab[i], operand_out);
      end
      step('{operand_load: 1'b1, sd_sel: SD_FULL, default: 1'b0}, 32'h12340000);
      step('{acc_reset: 1'b1, sd_sel: SD_NONE, default: 1'b0});
      step('{funnel_strobe: 1'b1, gate_operand: 1'b1, sd_sel: SD_LOW_HALF, default: 1'b0},
           32'hFFFF5678);
      chk_word("operand or storage", 32'h12345678, acc_out);
   endtask

   // halfword crossover with and without the accelerator option
   task automatic crossover;
      for (int acc = 0; acc < 2; acc++) begin
         apb(OFF_CTRL, 1'b1, 32'(acc));
         step('{operand_load: 1'b1, gate_cross: 1'b1, sd_sel: SD_NONE, default: 1'b0}, '0,
              32'h0000ABCD);
         chk_word("crossover", acc ? 32'hABCD0000 : 32'h00000000, operand_out);
      end
   endtask

   // one addition pass, latches, carry word and realignment
   task automatic add_case(input word_t a, input word_t b, input logic sub);
      logic [0:32] k0;
      logic [0:32] k;
      k0 = carry_ref(a, b, 1'b0);
      k = carry_ref(a, b, sub);
      step('{mirror_reset: 1'b1, acc_reset: 1'b1, latch_clear: 1'b1, sd_sel: SD_NONE,
             default: 1'b0});
      step('{operand_load: 1'b1, sd_sel: SD_FULL, default: 1'b0}, a);
      step('{funnel_strobe: 1'b1, sd_sel: SD_FULL, default: 1'b0}, b);
      apb(OFF_CARRY, 1'b0, '0);
      chk_word("carry word", k0[1:32], rd);
      step('{gate_carry: 1'b1, funnel_strobe: 1'b1, latch_strobe: 1'b1, subtract: sub,
             sd_sel: SD_NONE, default: 1'b0});
      chk_word("acc sum", b ^ k[1:32], acc_out);
      chk_bit("carry-out latch", k[0], carry_out_flag);
      chk_bit("high bit latch", k[1], high_carry_flag);
      apb(OFF_MIRROR, 1'b0, '0);
      chk_word("mirror held", b, rd);
      step('{mirror_copy_acc: 1'b1, sd_sel: SD_NONE, default: 1'b0});
      apb(OFF_MIRROR, 1'b0, '0);
      chk_word("mirror copy", b ^ k[1:32], rd);
   endtask

   // main sequence
   initial begin
      repeat (4) @(posedge ref_clk);
      rst_n <= 1'b1;
      reset_values();
      mirror_controls();
      funnel_selects();
      crossover();
      add_case(32'h0000FFFF, 32'h00000000, 1'b0);
      add_case(32'hC0000000, 32'h00000000, 1'b0);
      add_case(32'h00000000, 32'hFFFFFFFF, 1'b1);
      add_case(32'h12345678, 32'h0F0F0F0F, 1'b1);
      tally_and_finish();
   end
endmodule // carry_lookahead_adder_funnel_test

// File: carry_lookahead_network.sv
// eight groups of four carry positions with group bypass
module carry_lookahead_network
   import adder_funnel_pkg::*;
(
   input  word_t operand,
   input  word_t mirror,
   input  logic  carry_in,
   output word_t carry_vec,
   output logic  carry_top
);
   logic [0:GROUP_N] group_cin;

   // forced low-order carry enters the lowest group
   assign group_cin[GROUP_N] = carry_in;
   assign carry_top          = group_cin[0];

   for (genvar g = 0; g < GROUP_N; g++) begin : grp
      localparam int B = g * GROUP_W;
      logic [0:3] gen;
      logic [0:3] prop;
      logic [1:3] k;
      // generate where operand one meets mirror zero, propagate on mirror one
      assign gen  = operand[B +: GROUP_W] & ~mirror[B +: GROUP_W];
      assign prop = mirror[B +: GROUP_W];
      // internal ripple, low order toward high order
      assign k[3] = gen[3] | (prop[3] & group_cin[g + 1]);
      assign k[2] = gen[2] | (prop[2] & k[3]);
      assign k[1] = gen[1] | (prop[1] & k[2]);
      // top position collects the group carry directly
      assign group_cin[g] = gen[0] | (prop[0] & gen[1]) | (prop[0] & prop[1] & gen[2])
                          | (prop[0] & prop[1] & prop[2] & gen[3])
                          | ((&prop) & group_cin[g + 1]);
      assign carry_vec[B +: GROUP_W] = {group_cin[g], k[1:3]};
   end
endmodule // carry_lookahead_network

// File: register_input_funnel.sv
// or-combining funnel of storage, carry, operand and crossover sources
module register_input_funnel
   import adder_funnel_pkg::*;
(
   input  sd_sel_t sd_sel,
   input  prec_t   prec,
   input  logic    odd_addr,
   input  word_t   storage_data,
   input  word_t   hw_data,
   input  word_t   carry_word,
   input  word_t   operand,
   input  logic    gate_carry,
   input  logic    gate_operand,
   input  logic    cross_en,
   output word_t   funnel
);
   word_t sd_mask;
   word_t cross_word;

   // storage-data range select
   always_comb begin
      case (sd_sel)
         SD_FULL:      sd_mask = WORD_ONES;
         SD_LOW_HALF:  sd_mask = MASK_LOW_HALF;
         SD_HIGH_HALF: sd_mask = MASK_HIGH_HALF;
         SD_DISP:      sd_mask = MASK_DISP;
         SD_IMM_BYTE:  sd_mask = odd_addr ? MASK_IMM_ODD : MASK_IMM_EVEN;
         SD_FP_LONG: begin
            case (prec)
               PREC_8:  sd_mask = MASK_PREC_8;
               PREC_10: sd_mask = MASK_PREC_10;
               PREC_12: sd_mask = MASK_PREC_12;
               default: sd_mask = WORD_ONES;
            endcase
         end
         default:      sd_mask = WORD_ZERO;
      endcase
   end

   // hardware funnel low half moved into high half
   assign cross_word = cross_en ? {hw_data[16:31], 16'h0000} : WORD_ZERO;

   // all enabled sources merge by or
   assign funnel = (storage_data & sd_mask)
                 | (gate_carry ? carry_word : WORD_ZERO)
                 | (gate_operand ? operand : WORD_ZERO)
                 | cross_word;
endmodule // register_input_funnel

// File: sequencer_model.sv
// instruction sequencer stand-in that feeds the slice control strobes
module sequencer_model
   import adder_funnel_pkg::*;
(
   input  ctl_t want,
   output ctl_t ctl
);
   timeunit 1ns;
   timeprecision 1ps;

   // pass requests on, holding the mirror off while carries are gated
   always_comb begin
      ctl               = want;
      ctl.mirror_decond = want.mirror_decond | want.gate_carry;
   end
endmodule // sequencer_model
